// File: verilog/dttc_pkg.sv
/*
 * Constants shared by the toggle and thermal control block: channel
 * counts, control word decode, control register fields and the
 * software register map.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dttc_pkg;

  // ************************************************************
  // Channel organisation
  // ************************************************************
  localparam int NUM_CH   = 40;
  localparam int GRP_SIZE = 8;
  localparam int DATA_W   = 14;
  localparam int CHAN_W   = 6;

  // ************************************************************
  // Data word decode
  // ************************************************************
  localparam logic [1:0]  REGSEL_CTRL = 2'h0;
  localparam logic [1:0]  REGSEL_DATA = 2'h3;
  localparam logic [5:0]  CHAN_CTRL   = 6'h0C;
  localparam logic [5:0]  CHAN_PWRUP  = 6'h09;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int          CR_TGL_LSB  = 2;
  localparam int          CR_THERM    = 8;
  localparam logic [13:0] CTRL_RST    = 14'h0000;

  // ************************************************************
  // Software register map
  // ************************************************************
  localparam int          ADDR_W      = 8;
  localparam int          BUS_W       = 32;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_PWRUP   = 8'h08;
  localparam int          ST_SHUT     = 0;
  localparam int          ST_HOT      = 1;
  localparam int          ST_PHASE    = 8;

endpackage

// File: verilog/dttc_top.sv
/*
 * Toggle mode and thermal shutdown control for a multi-channel
 * converter: per-channel A and B registers, load strobe driven
 * output update, and an over-temperature power-down latch.
 * Assumes: data words arrive already deframed on the i_clk domain;
 * the load strobe and the over-temperature flag come from pins.
 */
// Local design decisions: the strobed register port and the register offsets.
// What this block does
// - Every channel has an A and a B data register feeding its output.
// - B register writes take effect only while the channel toggles.
// - First load strobe after toggle setup outputs the A value.
// - Later load strobes swap each toggled output between A and B.
// - Five toggle enable bits each cover a group of eight channels.
// - First strobe after toggle disable loads A and stops toggling.
// - Thermal monitor acts only while its control bit is set.
// - Hot die with monitor enabled powers down all output amplifiers.
// - Shutdown holds until soft power-up while the die is cool.
// - Clearing the monitor enable also leaves thermal shutdown.
// - Control word is register select 00 with channel address 001100.
// - Toggle is unavailable while burst write mode is active.
`timescale 1ns/10ps

module dttc_top
  import dttc_pkg::*;
#(
  parameter int CH_N = NUM_CH,
  parameter int DW   = DATA_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_output_load_strobe_n,
  input  wire logic              i_over_temp,
  input  wire logic              i_burst_mode,
  input  wire logic              i_word_stb,
  input  wire logic [1:0]        i_word_reg_sel,
  input  wire logic [CHAN_W-1:0] i_word_chan,
  input  wire logic              i_word_b_sel,
  input  wire logic [DW-1:0]     i_word_data,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [BUS_W-1:0]  i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [BUS_W-1:0]  o_rdata,
  output logic      [CH_N*DW-1:0] o_dac_code,
  output logic                   o_amp_pwr_down
);

  localparam int GRP_N = (CH_N + GRP_SIZE - 1) / GRP_SIZE;

  // ************************************************************
  // Assertion clocking
  // ************************************************************
  // Every check runs on i_clk and sleeps while reset is held
  default clocking cb_main @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] ld_sync_q;
  logic       ld_last_q;
  logic [1:0] hot_sync_q;
  logic       ld_pulse;
  logic       hot;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      // Idle high, so leaving reset never looks like a falling strobe
      ld_sync_q  <= 2'h3;
      ld_last_q  <= 1'b1;
      hot_sync_q <= 2'h0;
    end else begin
      ld_sync_q  <= {ld_sync_q[0], i_output_load_strobe_n};
      ld_last_q  <= ld_sync_q[1];
      hot_sync_q <= {hot_sync_q[0], i_over_temp};
    end
  end

  // Falling edge of the active-low strobe, seen after the 2-FF chain
  assign ld_pulse = ld_last_q & ~ld_sync_q[1];
  assign hot      = hot_sync_q[1];

  // One strobe must give one swap, so the pulse lasts one cycle
  a_one_pulse: assert property (
    ld_pulse |=> !ld_pulse)
    else $error("load strobe pulse longer than one cycle");

  // ************************************************************
  // Word and bus decode
  // ************************************************************
  logic [13:0] ctrl_q;
  logic [13:0] ctrl_d;
  logic        ctrl_word;
  logic        pwrup_word;
  logic        data_word;
  logic        bus_ctrl_wr;
  logic        soft_pwrup;
  logic        mon_en;

  assign ctrl_word   = i_word_stb & (i_word_reg_sel == REGSEL_CTRL)
                     & (i_word_chan == CHAN_CTRL);
  assign pwrup_word  = i_word_stb & (i_word_reg_sel == REGSEL_CTRL)
                     & (i_word_chan == CHAN_PWRUP);
  assign data_word   = i_word_stb & (i_word_reg_sel == REGSEL_DATA);
  assign bus_ctrl_wr = i_wr & (i_addr == OFS_CTRL);
  assign soft_pwrup  = pwrup_word | (i_wr & (i_addr == OFS_PWRUP));
  // Software bus wins if both paths write control in one cycle
  assign ctrl_d      = bus_ctrl_wr ? i_wdata[13:0]
                     : ctrl_word ? i_word_data[13:0] : ctrl_q;
  assign mon_en      = ctrl_q[CR_THERM];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ************************************************************
  // Toggle groups
  // ************************************************************
  logic [GRP_N-1:0] tgl_en;
  logic [GRP_N-1:0] prev_en_q;
  logic [GRP_N-1:0] armed_q;
  logic [GRP_N-1:0] armed_d;
  logic [GRP_N-1:0] use_a;
  logic [GRP_N-1:0] phase_q;
  logic [GRP_N-1:0] phase_d;

  sequence s_strobe;
    ld_pulse;
  endsequence

  for (genvar g = 0; g < GRP_N; g++) begin : g_grp
    // Burst mode masks toggling; the bits stay stored
    assign tgl_en[g]  = ctrl_q[CR_TGL_LSB + g] & ~i_burst_mode;
    // A strobe in the very cycle toggle turns on counts as first
    assign use_a[g]   = ~tgl_en[g] | armed_q[g]
                      | ~prev_en_q[g];
    assign phase_d[g] = ld_pulse ? (use_a[g] ? 1'b0 : ~phase_q[g])
                      : phase_q[g];
    assign armed_d[g] = ld_pulse ? 1'b0
                      : (armed_q[g] | (tgl_en[g] & ~prev_en_q[g]));

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        prev_en_q[g] <= 1'b0;
        armed_q[g]   <= 1'b0;
        phase_q[g]   <= 1'b0;
      end else begin
        prev_en_q[g] <= tgl_en[g];
        armed_q[g]   <= armed_d[g];
        phase_q[g]   <= phase_d[g];
      end
    end

    property p_first_a;
      (tgl_en[g] & (armed_q[g] | ~prev_en_q[g])) ##0 s_strobe
        |=> !phase_q[g];
    endproperty
    a_first_strobe_a: assert property (p_first_a)
      else $error("first toggle strobe did not select A");

    a_later_swap: assert property (
      (tgl_en[g] & prev_en_q[g] & ~armed_q[g]) ##0 s_strobe
        |=> phase_q[g] != $past(phase_q[g]))
      else $error("toggle strobe did not swap source");

    a_disable_to_a: assert property (
      !tgl_en[g] ##0 s_strobe |=> !phase_q[g])
      else $error("strobe with toggle off did not pick A");

    a_no_strobe_hold: assert property (
      !ld_pulse |=> phase_q[g] == $past(phase_q[g]))
      else $error("source changed without a strobe");

    // The arm flag is what makes the first strobe show A
    a_arm_on_enable: assert property (
      (tgl_en[g] & !prev_en_q[g] & !ld_pulse) |=> armed_q[g])
      else $error("toggle enable did not arm the group");

    a_arm_spent: assert property (
      ld_pulse |=> !armed_q[g])
      else $error("arm flag survived a strobe");
  end

  // ************************************************************
  // Channel registers and outputs
  // ************************************************************
  logic [DW-1:0] a_mem [CH_N];
  logic [DW-1:0] b_mem [CH_N];
  logic [DW-1:0] dac_q [CH_N];
  logic [CH_N-1:0] a_we;
  logic [CH_N-1:0] b_we;

  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    localparam int GRP = c / GRP_SIZE;
    localparam logic [CHAN_W-1:0] CH_ADDR = CHAN_W'(c);

    assign a_we[c] = data_word & (i_word_chan == CH_ADDR)
                   & ~i_word_b_sel;
    assign b_we[c] = data_word & (i_word_chan == CH_ADDR)
                   & i_word_b_sel & tgl_en[GRP];

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        a_mem[c] <= '0;
        b_mem[c] <= '0;
        dac_q[c] <= '0;
      end else begin
        if (a_we[c]) begin
          a_mem[c] <= i_word_data;
        end
        if (b_we[c]) begin
          b_mem[c] <= i_word_data;
        end
        if (ld_pulse) begin
          // Old register value is used if a write lands on the strobe
          dac_q[c] <= phase_d[GRP] ? b_mem[c] : a_mem[c];
        end
      end
    end

    assign o_dac_code[c*DW +: DW] = dac_q[c];

    a_output_source: assert property (
      ld_pulse |=> dac_q[c] == ($past(phase_d[GRP])
        ? $past(b_mem[c]) : $past(a_mem[c])))
      else $error("channel output not loaded from its source");

    a_code_hold: assert property (
      !ld_pulse |=> dac_q[c] == $past(dac_q[c]))
      else $error("channel output moved without a strobe");

    a_a_reg_write: assert property (
      (data_word & !i_word_b_sel & (i_word_chan == CH_ADDR))
        |=> a_mem[c] == $past(i_word_data))
      else $error("A register write was lost");

    // Uses the raw control bit so a wrong group map is caught here
    a_b_reg_write: assert property (
      (data_word & i_word_b_sel & (i_word_chan == CH_ADDR)
        & ctrl_q[CR_TGL_LSB + c / GRP_SIZE] & !i_burst_mode)
        |=> b_mem[c] == $past(i_word_data))
      else $error("B register write refused with toggle on");

    a_b_write_gate: assert property (
      (data_word & i_word_b_sel & (i_word_chan == CH_ADDR)
        & !tgl_en[GRP]) |=> b_mem[c] == $past(b_mem[c]))
      else $error("B register loaded with toggle off");

    a_burst_no_b: assert property (
      i_burst_mode |-> !b_we[c])
      else $error("B register write during burst mode");
  end

  // ************************************************************
  // Thermal shutdown
  // ************************************************************
  logic shut_d;

  // Heat sets the latch while the monitor is enabled and wins over a power-up in the same cycle
  assign shut_d = mon_en & (hot
                | (o_amp_pwr_down & ~(soft_pwrup & ~hot)));

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_amp_pwr_down <= 1'b0;
    end else begin
      o_amp_pwr_down <= shut_d;
    end
  end

  a_hot_shutdown: assert property (
    (mon_en & hot) |=> o_amp_pwr_down)
    else $error("hot die did not power down amplifiers");

  a_monitor_off: assert property (
    !mon_en |=> !o_amp_pwr_down)
    else $error("shutdown active with monitor disabled");

  a_shut_holds: assert property (
    (o_amp_pwr_down & mon_en & !soft_pwrup) |=> o_amp_pwr_down)
    else $error("shutdown released without power-up");

  a_pwrup_cool: assert property (
    (o_amp_pwr_down & soft_pwrup & !hot) |=> !o_amp_pwr_down)
    else $error("cool power-up did not release shutdown");

  // Set wins: heat beside a power-up keeps the amplifiers off
  a_hot_beats_pwrup: assert property (
    (mon_en & hot & soft_pwrup) |=> o_amp_pwr_down)
    else $error("power-up while hot released shutdown");

  // Only heat may start a shutdown, never a stray command
  a_cool_stays_up: assert property (
    (!o_amp_pwr_down & !hot) |=> !o_amp_pwr_down)
    else $error("amplifiers powered down with a cool die");

  // ************************************************************
  // Register read port
  // ************************************************************
  logic [BUS_W-1:0] status_w;
  logic [BUS_W-1:0] rsel;
  logic [BUS_W-1:0] rdata_d;

  // Each field is placed at its named bit so the map can move freely
  assign status_w = (BUS_W'(phase_q) << ST_PHASE)
                  | (BUS_W'(hot) << ST_HOT)
                  | (BUS_W'(o_amp_pwr_down) << ST_SHUT);
  assign rsel     = (i_addr == OFS_CTRL)   ? BUS_W'(ctrl_q)
                  : (i_addr == OFS_STATUS) ? status_w
                  : '0;
  assign rdata_d  = i_rd ? rsel : '0;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= rdata_d;
    end
  end

  a_ctrl_word: assert property (
    (ctrl_word & !bus_ctrl_wr) |=> ctrl_q == $past(i_word_data))
    else $error("control word did not load control register");

  a_other_word: assert property (
    (i_word_stb & (i_word_chan != CHAN_CTRL) & !bus_ctrl_wr)
      |=> ctrl_q == $past(ctrl_q))
    else $error("non-control word changed the control register");

  a_bus_ctrl: assert property (
    bus_ctrl_wr |=> ctrl_q == $past(i_wdata[13:0]))
    else $error("bus write did not load control register");

  a_read_answer: assert property (
    (i_rd & (i_addr == OFS_CTRL)) |=> o_rdata == BUS_W'($past(ctrl_q)))
    else $error("control read returned the wrong value");

  a_read_once: assert property (
    !i_rd |=> o_rdata == '0)
    else $error("read data outside the read answer cycle");

endmodule

// File: tb/dttc_host.sv
/*
 * Host controller model: sends deframed data words and pulses the
 * active-low load strobe pin.
 * Assumes the caller steps it from one process on the i_clk domain.
 */
`timescale 1ns/10ps

module dttc_host
  import dttc_pkg::*;
(
  input  wire logic              i_clk,
  output logic                   o_stb_n,
  output logic                   o_wstb,
  output logic [1:0]             o_sel,
  output logic [CHAN_W-1:0]      o_chan,
  output logic                   o_bsel,
  output logic [DATA_W-1:0]      o_data
);
  initial begin
    o_stb_n = 1'h1;
    o_wstb  = 1'h0;
    o_sel   = 2'h1;
    o_chan  = 6'h3F;
    o_bsel  = 1'h0;
    o_data  = 14'h2AAA;
  end

  // Idle word fields show the inverse so stale data never passes
  task automatic word(logic [1:0] s, logic [CHAN_W-1:0] c, logic b,
                      logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_wstb <= 1'h1;
    o_sel  <= s;
    o_chan <= c;
    o_bsel <= b;
    o_data <= d;
    @(posedge i_clk);
    o_wstb <= 1'h0;
    o_sel  <= ~s;
    o_chan <= ~c;
    o_bsel <= ~b;
    o_data <= ~d;
  endtask

  // Low and high times well above the two-cycle minimum
  task automatic load();
    @(posedge i_clk);
    o_stb_n <= 1'h0;
    repeat (3) @(posedge i_clk);
    o_stb_n <= 1'h1;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

// File: tb/test_dac_toggle_thermal_control.sv
/*
 * Self-checking bench: toggle groups, load strobe, thermal shutdown
 * and the register port of dttc_top.
 * Assumes dttc_host supplies data words and the load strobe pin.
 */
`timescale 1ns/10ps

module test_dac_toggle_thermal_control
  import dttc_pkg::*;
;
  logic                     i_clk = 1'h0;
  logic                     i_sys_rst, i_over_temp, i_burst_mode;
  logic                     i_wr, i_rd;
  logic [ADDR_W-1:0]        i_addr;
  logic [BUS_W-1:0]         i_wdata, o_rdata, rv;
  logic [NUM_CH*DATA_W-1:0] o_dac_code;
  logic                     o_amp_pwr_down, stb_n, wstb, bsel;
  logic [1:0]               sel;
  logic [CHAN_W-1:0]        chan;
  logic [DATA_W-1:0]        data, a_v[3], b_v[3];
  int                       failures, compares;
  int                       chs[3] = '{3, 9, 39};

  always #4 i_clk = ~i_clk;

  dttc_host host (.i_clk(i_clk), .o_stb_n(stb_n), .o_wstb(wstb),
    .o_sel(sel), .o_chan(chan), .o_bsel(bsel), .o_data(data));

  dttc_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_output_load_strobe_n(stb_n), .i_over_temp(i_over_temp),
    .i_burst_mode(i_burst_mode), .i_word_stb(wstb),
    .i_word_reg_sel(sel), .i_word_chan(chan), .i_word_b_sel(bsel),
    .i_word_data(data), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_dac_code(o_dac_code), .o_amp_pwr_down(o_amp_pwr_down));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic final_report();
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [BUS_W-1:0] e, logic [BUS_W-1:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [BUS_W-1:0] d);
    @(posedge i_clk);
    i_wr    <= 1'h1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'h0;
    #1;
  endtask

  task automatic rd(logic [ADDR_W-1:0] a);
    @(posedge i_clk);
    i_rd   <= 1'h1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'h0;
    #1;
    rv = o_rdata;
    @(posedge i_clk);
    #1;
    chk("rdata_idle", '0, o_rdata);
  endtask

  function automatic logic [DATA_W-1:0] exp_code(int i, logic use_b);
    return use_b ? b_v[i] : a_v[i];
  endfunction

  task automatic chk_dac(logic [2:0] use_b);
    #1;
    for (int i = 0; i < 3; i++) begin
      chk("dac_code", BUS_W'(exp_code(i, use_b[i])),
          BUS_W'(o_dac_code[chs[i]*DATA_W +: DATA_W]));
    end
  endtask

  task automatic pwr(logic e, int n);
    repeat (n) @(posedge i_clk);
    #1;
    chk("amp_pwr_down", BUS_W'(e), BUS_W'(o_amp_pwr_down));
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    final_report();
  end

  initial begin
    void'($urandom(53221));
    {i_sys_rst, i_over_temp, i_burst_mode, i_wr, i_rd} = 5'h10;
    i_addr  = 8'h00;
    i_wdata = 32'h0000_0000;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    rd(OFS_CTRL);
    chk("ctrl_rst", 32'h0, rv);
    pwr(1'h0, 0);
    host.word(REGSEL_CTRL, CHAN_CTRL, 1'h0, 14'h0044);
    host.word(REGSEL_CTRL, 6'h0D, 1'h0, 14'h3FFF);
    rd(OFS_CTRL);
    chk("ctrl_word", 32'h0044, rv);
    // Channel 9 sits in a group left off, so its B write is lost
    for (int i = 0; i < 3; i++) begin
      a_v[i] = DATA_W'($urandom());
      b_v[i] = (i == 1) ? 14'h0000 : DATA_W'($urandom());
      host.word(REGSEL_DATA, CHAN_W'(chs[i]), 1'h0, a_v[i]);
      host.word(REGSEL_DATA, CHAN_W'(chs[i]), 1'h1,
                (i == 1) ? DATA_W'($urandom()) : b_v[i]);
    end
    for (int k = 0; k < 4; k++) begin
      host.load();
      chk_dac(k[0] ? 3'h5 : 3'h0);
    end
    host.word(REGSEL_CTRL, CHAN_CTRL, 1'h0, 14'h0000);
    host.load();
    chk_dac(3'h0);
    host.load();
    chk_dac(3'h0);
    // Toggle is on, so only burst mode can refuse this B write
    host.word(REGSEL_CTRL, CHAN_CTRL, 1'h0, 14'h007C);
    @(posedge i_clk);
    i_burst_mode <= 1'h1;
    host.word(REGSEL_DATA, CHAN_W'(chs[2]), 1'h1, ~b_v[2]);
    @(posedge i_clk);
    i_burst_mode <= 1'h0;
    host.load();
    chk_dac(3'h0);
    host.load();
    chk_dac(3'h7);
    rd(OFS_STATUS);
    chk("status_phase", 32'h1F00, rv);
    @(posedge i_clk);
    i_over_temp <= 1'h1;
    pwr(1'h0, 6);
    wr(OFS_CTRL, 32'h0000_0100);
    pwr(1'h1, 4);
    wr(OFS_PWRUP, 32'h0000_0001);
    pwr(1'h1, 2);
    rd(OFS_STATUS);
    chk("status", 32'h3, rv & 32'h3);
    @(posedge i_clk);
    i_over_temp <= 1'h0;
    pwr(1'h1, 6);
    wr(OFS_PWRUP, 32'h0000_0001);
    pwr(1'h0, 2);
    @(posedge i_clk);
    i_over_temp <= 1'h1;
    pwr(1'h1, 6);
    @(posedge i_clk);
    i_over_temp <= 1'h0;
    pwr(1'h1, 4);
    host.word(REGSEL_CTRL, CHAN_PWRUP, 1'h0, 14'h0000);
    pwr(1'h0, 1);
    @(posedge i_clk);
    i_over_temp <= 1'h1;
    pwr(1'h1, 6);
    wr(OFS_CTRL, 32'h0000_0000);
    pwr(1'h0, 2);
    @(posedge i_clk);
    i_over_temp <= 1'h0;
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    chk("unmapped", 32'h0, rv);
    rd(OFS_CTRL);
    chk("ctrl_bus", 32'h0, rv);
    final_report();
  end
endmodule
